//--- src/status_output_pkg.sv
// Package for the multi-function status output block: register map,
// reset values, function codes, timing constants and carrier structs.
// Assumes a single 10 MHz control clock and an APB register port.
package status_output_pkg;

	// Clock and torque-timer base.
	localparam int CLK_PERIOD_NS = 100;
	localparam int TORQUE_TICK_NS = 1000000;
	localparam int TORQUE_TICK_CYCLES = TORQUE_TICK_NS / CLK_PERIOD_NS;

	// Register byte offsets.
	localparam logic [7:0] OFS_FUNC_SEL0 = 8'h00;
	localparam logic [7:0] OFS_FUNC_SEL1 = 8'h04;
	localparam logic [7:0] OFS_FUNC_SEL2 = 8'h08;
	localparam logic [7:0] OFS_SPEED_LEVEL_A = 8'h0C;
	localparam logic [7:0] OFS_SPEED_WIDTH_A = 8'h10;
	localparam logic [7:0] OFS_SPEED_LEVEL_B = 8'h14;
	localparam logic [7:0] OFS_SPEED_WIDTH_B = 8'h18;
	localparam logic [7:0] OFS_TORQUE_LEVEL_1 = 8'h1C;
	localparam logic [7:0] OFS_TORQUE_TIME_1 = 8'h20;
	localparam logic [7:0] OFS_TORQUE_LEVEL_2 = 8'h24;
	localparam logic [7:0] OFS_TORQUE_TIME_2 = 8'h28;
	localparam logic [7:0] OFS_CONFIG = 8'h2C;
	localparam logic [7:0] OFS_UNDERVOLT = 8'h30;
	localparam logic [7:0] OFS_PASSTHRU = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;

	// Field positions in the configuration register.
	localparam int CFG_TORQUE1_UNDER = 0;
	localparam int CFG_TORQUE2_UNDER = 1;
	localparam int CFG_PROG_RUN_SEL = 2;
	localparam int CFG_SAFE_READY_SEL = 3;

	// Function codes; bit 8 selects the inverted terminal level.
	localparam int INVERT_BIT = 8;
	localparam logic [7:0] FN_SPEED_DET_A = 8'h05;
	localparam logic [7:0] FN_READY = 8'h06;
	localparam logic [7:0] FN_UNDERVOLT = 8'h07;
	localparam logic [7:0] FN_INHIBIT = 8'h08;
	localparam logic [7:0] FN_TORQUE_1 = 8'h0B;
	localparam logic [7:0] FN_FAULT = 8'h0E;
	localparam logic [7:0] FN_PASSTHRU = 8'h0F;
	localparam logic [7:0] FN_MINOR = 8'h10;
	localparam logic [7:0] FN_RESET_TRY = 8'h11;
	localparam logic [7:0] FN_TIMER = 8'h12;
	localparam logic [7:0] FN_AGREE_B = 8'h13;
	localparam logic [7:0] FN_BAND_B = 8'h14;
	localparam logic [7:0] FN_DET_B_OPEN = 8'h15;
	localparam logic [7:0] FN_DET_B = 8'h16;
	localparam logic [7:0] FN_TORQUE_2 = 8'h18;

	// Reset values.
	localparam logic [8:0] FUNC_SEL0_RST = 9'h00E;
	localparam logic [8:0] FUNC_SEL1_RST = 9'h006;
	localparam logic [8:0] FUNC_SEL2_RST = 9'h050;
	localparam logic [15:0] PARAM_RST = 16'h0000;
	localparam logic [3:0] CONFIG_RST = 4'h0;
	localparam logic [2:0] PASSTHRU_RST = 3'h0;

	// Fault codes of the two control-processor faults.
	localparam logic [7:0] CONTROL_FAULT_A = 8'h00;
	localparam logic [7:0] CONTROL_FAULT_B = 8'h01;

	// Internal conditions that a terminal may select.
	typedef struct packed {
		logic det_a;
		logic ready;
		logic undervolt;
		logic inhibit;
		logic torque1;
		logic torque2;
		logic fault;
		logic minor;
		logic reset_try;
		logic timer;
		logic agree_b;
		logic band_b;
		logic det_b_closed;
		logic det_b;
	} cond_s;

	// Software-written detection settings.
	typedef struct packed {
		logic [15:0] speed_level_a;
		logic [15:0] speed_width_a;
		logic [15:0] speed_level_b;
		logic [15:0] speed_width_b;
		logic [15:0] torque_level_1;
		logic [15:0] torque_time_1;
		logic [15:0] torque_level_2;
		logic [15:0] torque_time_2;
		logic [15:0] undervolt_trip_level;
		logic [3:0] config_bits;
	} cfg_s;

endpackage

//--- src/status_output_select.sv
// Multi-function status outputs of a motor drive: three terminals, each
// driven by a selectable internal condition, with settings over APB.
// Assumes all condition inputs are synchronous to pclk.
//
// Overview of operation
// RULE_01: Code 5: speed magnitude detection with hysteresis.
// RULE_02: Magnitude detection identical in both directions.
// RULE_03: Ready only when drive can run motor.
// RULE_04: Safe disable open blocks ready when selected.
// RULE_05: Travel commands ignored while not ready.
// RULE_06: Code 7: undervoltage or bus circuit fault.
// RULE_07: Code 8: output stage inhibited.
// RULE_08: Code B: torque beyond level one, timed.
// RULE_09: Code 18: torque beyond level two, timed.
// RULE_10: Code E: fault, except control-processor faults.
// RULE_11: Code F: terminal follows software pass-through bit.
// RULE_12: Code 10: minor fault present.
// RULE_13: Code 11: fault reset being attempted.
// RULE_14: Code 12: delay timer output.
// RULE_15: Code 13: speed within width of reference.
// RULE_16: Code 14: speed and reference in signed band.
// RULE_17: Code 15: opens above band, recloses below level.
// RULE_18: Code 16: signed speed detection with hysteresis.
// RULE_19: Codes plus one hundred invert terminal level.
// RULE_20: Evaluate every cycle; terminals low in reset.
`timescale 1ns/1ps
`default_nettype none

module status_output_select
	import status_output_pkg::*;
#(
	parameter int TICK_CYCLES = TORQUE_TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [15:0] speed,
	input wire logic signed [15:0] speed_ref,
	input wire logic [15:0] torque,
	input wire logic [15:0] dc_bus_voltage,
	input wire logic [15:0] control_supply_voltage,
	input wire logic dc_bus_fault,
	input wire logic fault_active,
	input wire logic [7:0] fault_code,
	input wire logic supply_failure,
	input wire logic param_error,
	input wire logic overvoltage,
	input wire logic motor_stopped,
	input wire logic param_editing,
	input wire logic [1:0] safe_disable_open,
	input wire logic output_inhibited,
	input wire logic minor_fault,
	input wire logic [2:0] reset_attempt,
	input wire logic timer_output,
	input wire logic up_cmd,
	input wire logic down_cmd,
	output logic [2:0] terminal,
	output logic drive_ready,
	output logic up_accept,
	output logic down_accept
);

	// Sign-extends a signed speed to the comparison width.
	function automatic logic signed [17:0] sext(input logic signed [15:0] v);
		sext = {{2{v[15]}}, v};
	endfunction
	// Zero-extends an unsigned setting to the comparison width.
	function automatic logic signed [17:0] zext(input logic [15:0] v);
		zext = {2'b00, v};
	endfunction
	// True when x lies within centre plus or minus width.
	function automatic logic in_band(input logic signed [15:0] x, input logic signed [15:0] c,
			input logic [15:0] w);
		logic signed [17:0] d;
		d = sext(x) - sext(c);
		in_band = (d <= zext(w)) && (d >= -zext(w));
	endfunction
	// Maps a function code onto the selected condition and applies inversion.
	function automatic logic select_level(input logic [8:0] code, input cond_s c, input logic pass);
		logic lvl;
		lvl = 1'b0;
		unique case (code[7:0])
			FN_SPEED_DET_A: lvl = c.det_a;
			FN_READY: lvl = c.ready;
			FN_UNDERVOLT: lvl = c.undervolt;
			FN_INHIBIT: lvl = c.inhibit;
			FN_TORQUE_1: lvl = c.torque1;
			FN_FAULT: lvl = c.fault;
			FN_PASSTHRU: lvl = pass;
			FN_MINOR: lvl = c.minor;
			FN_RESET_TRY: lvl = c.reset_try;
			FN_TIMER: lvl = c.timer;
			FN_AGREE_B: lvl = c.agree_b;
			FN_BAND_B: lvl = c.band_b;
			FN_DET_B_OPEN: lvl = c.det_b_closed;
			FN_DET_B: lvl = c.det_b;
			FN_TORQUE_2: lvl = c.torque2;
			default: lvl = 1'b0;
		endcase
		// RULE_19 inverse output
		select_level = lvl ^ code[INVERT_BIT];
	endfunction

	logic [8:0] func_sel [3];
	cfg_s cfg;
	logic [2:0] passthru;
	cond_s cond;
	logic det_a;
	logic det_b;
	logic det_b_open;
	logic next_det_a;
	logic next_det_b;
	logic next_det_b_open;
	logic [13:0] tick_cnt;
	logic tick;
	logic [15:0] torque_cnt [2];
	logic [1:0] torque_beyond;
	logic [1:0] torque_det;
	logic [16:0] speed_mag;
	logic [2:0] next_terminal;
	logic setup;
	logic access;

	assign setup = psel && !penable;
	assign access = psel && penable && pready;

	// Register reads; unmapped addresses answer zero with an error flag.
	function automatic logic [32:0] read_reg(input logic [7:0] a);
		read_reg = '0;
		unique case (a)
			OFS_FUNC_SEL0: read_reg[8:0] = func_sel[0];
			OFS_FUNC_SEL1: read_reg[8:0] = func_sel[1];
			OFS_FUNC_SEL2: read_reg[8:0] = func_sel[2];
			OFS_SPEED_LEVEL_A: read_reg[15:0] = cfg.speed_level_a;
			OFS_SPEED_WIDTH_A: read_reg[15:0] = cfg.speed_width_a;
			OFS_SPEED_LEVEL_B: read_reg[15:0] = cfg.speed_level_b;
			OFS_SPEED_WIDTH_B: read_reg[15:0] = cfg.speed_width_b;
			OFS_TORQUE_LEVEL_1: read_reg[15:0] = cfg.torque_level_1;
			OFS_TORQUE_TIME_1: read_reg[15:0] = cfg.torque_time_1;
			OFS_TORQUE_LEVEL_2: read_reg[15:0] = cfg.torque_level_2;
			OFS_TORQUE_TIME_2: read_reg[15:0] = cfg.torque_time_2;
			OFS_CONFIG: read_reg[3:0] = cfg.config_bits;
			OFS_UNDERVOLT: read_reg[15:0] = cfg.undervolt_trip_level;
			OFS_PASSTHRU: read_reg[2:0] = passthru;
			OFS_STATUS: read_reg[17:0] = {cond, drive_ready, terminal};
			default: read_reg[32] = 1'b1;
		endcase
	endfunction

	// Decoded read word; a process rather than an assign so that it follows the register contents.
	logic [32:0] rd_word;
	always_comb rd_word = read_reg(paddr);

	// APB answer: registered in the setup cycle, so access ends with no wait.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			prdata <= (setup && !pwrite) ? rd_word[31:0] : 32'h0000_0000;
			pslverr <= setup && rd_word[32];
		end
	end

	// Register writes take effect at the completing access edge only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_sel[0] <= FUNC_SEL0_RST;
			func_sel[1] <= FUNC_SEL1_RST;
			func_sel[2] <= FUNC_SEL2_RST;
			cfg <= '{speed_level_a: PARAM_RST, speed_width_a: PARAM_RST, speed_level_b: PARAM_RST,
				speed_width_b: PARAM_RST, torque_level_1: PARAM_RST, torque_time_1: PARAM_RST,
				torque_level_2: PARAM_RST, torque_time_2: PARAM_RST,
				undervolt_trip_level: PARAM_RST, config_bits: CONFIG_RST};
			passthru <= PASSTHRU_RST;
		end else if (access && pwrite) begin
			unique case (paddr)
				OFS_FUNC_SEL0: func_sel[0] <= pwdata[8:0];
				OFS_FUNC_SEL1: func_sel[1] <= pwdata[8:0];
				OFS_FUNC_SEL2: func_sel[2] <= pwdata[8:0];
				OFS_SPEED_LEVEL_A: cfg.speed_level_a <= pwdata[15:0];
				OFS_SPEED_WIDTH_A: cfg.speed_width_a <= pwdata[15:0];
				OFS_SPEED_LEVEL_B: cfg.speed_level_b <= pwdata[15:0];
				OFS_SPEED_WIDTH_B: cfg.speed_width_b <= pwdata[15:0];
				OFS_TORQUE_LEVEL_1: cfg.torque_level_1 <= pwdata[15:0];
				OFS_TORQUE_TIME_1: cfg.torque_time_1 <= pwdata[15:0];
				OFS_TORQUE_LEVEL_2: cfg.torque_level_2 <= pwdata[15:0];
				OFS_TORQUE_TIME_2: cfg.torque_time_2 <= pwdata[15:0];
				OFS_CONFIG: cfg.config_bits <= pwdata[3:0];
				OFS_UNDERVOLT: cfg.undervolt_trip_level <= pwdata[15:0];
				// RULE_11 software pass-through
				OFS_PASSTHRU: passthru <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Speed magnitude, so the unsigned detection ignores travel direction.
	// RULE_02 direction-free magnitude
	assign speed_mag = speed[15] ? 17'(-sext(speed)) : {1'b0, speed};

	// Next hysteresis states; the set edge wins over the release edge.
	always_comb begin
		// RULE_01 magnitude hysteresis
		next_det_a = det_a;
		if ({1'b0, speed_mag} > zext(cfg.speed_level_a)) begin
			next_det_a = 1'b1;
		end else if ($signed({1'b0, speed_mag}) < zext(cfg.speed_level_a) - zext(cfg.speed_width_a)) begin
			next_det_a = 1'b0;
		end
		// RULE_18 signed hysteresis
		next_det_b = det_b;
		if (sext(speed) > sext(cfg.speed_level_b)) begin
			next_det_b = 1'b1;
		end else if (sext(speed) < sext(cfg.speed_level_b) - zext(cfg.speed_width_b)) begin
			next_det_b = 1'b0;
		end
		// RULE_17 open above band
		next_det_b_open = det_b_open;
		if (sext(speed) > sext(cfg.speed_level_b) + zext(cfg.speed_width_b)) begin
			next_det_b_open = 1'b1;
		end else if (sext(speed) < sext(cfg.speed_level_b)) begin
			next_det_b_open = 1'b0;
		end
	end

	// Hysteresis state registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_a <= 1'b0;
			det_b <= 1'b0;
			det_b_open <= 1'b0;
		end else begin
			det_a <= next_det_a;
			det_b <= next_det_b;
			det_b_open <= next_det_b_open;
		end
	end

	// Millisecond tick for the torque timers; a parameter lets simulation shorten it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 14'h0000;
			tick <= 1'b0;
		end else if (tick_cnt >= 14'(TICK_CYCLES - 1)) begin
			tick_cnt <= 14'h0000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 14'h0001;
			tick <= 1'b0;
		end
	end

	// Torque is beyond its level: above for over-detection, below for under.
	assign torque_beyond[0] = cfg.config_bits[CFG_TORQUE1_UNDER] ? (torque < cfg.torque_level_1)
		: (torque > cfg.torque_level_1);
	assign torque_beyond[1] = cfg.config_bits[CFG_TORQUE2_UNDER] ? (torque < cfg.torque_level_2)
		: (torque > cfg.torque_level_2);
	// RULE_08 timed level one
	assign torque_det[0] = torque_beyond[0] && (torque_cnt[0] > cfg.torque_time_1);
	// RULE_09 timed level two
	assign torque_det[1] = torque_beyond[1] && (torque_cnt[1] > cfg.torque_time_2);

	// Duration counters restart whenever torque returns inside its level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_cnt[0] <= 16'h0000;
			torque_cnt[1] <= 16'h0000;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!torque_beyond[i]) begin
					torque_cnt[i] <= 16'h0000;
				end else if (tick && torque_cnt[i] != 16'hFFFF) begin
					torque_cnt[i] <= torque_cnt[i] + 16'h0001;
				end
			end
		end
	end

	// Condition vector from the current inputs and the next hysteresis states.
	always_comb begin
		cond.det_a = next_det_a;
		// RULE_06 undervoltage and bus fault
		cond.undervolt = (dc_bus_voltage < cfg.undervolt_trip_level)
			|| (control_supply_voltage < cfg.undervolt_trip_level) || dc_bus_fault;
		// RULE_03 ready blockers
		cond.ready = !fault_active && !supply_failure && !param_error
			&& !(motor_stopped && (overvoltage || cond.undervolt))
			&& !(param_editing && !cfg.config_bits[CFG_PROG_RUN_SEL])
			// RULE_04 safe disable blocks ready
			&& !(!cfg.config_bits[CFG_SAFE_READY_SEL] && (|safe_disable_open));
		// RULE_07 inhibited output stage
		cond.inhibit = output_inhibited;
		cond.torque1 = torque_det[0];
		cond.torque2 = torque_det[1];
		// RULE_10 control faults excluded
		cond.fault = fault_active && fault_code != CONTROL_FAULT_A && fault_code != CONTROL_FAULT_B;
		// RULE_12 minor fault present
		cond.minor = minor_fault;
		// RULE_13 any reset source
		cond.reset_try = |reset_attempt;
		// RULE_14 delay timer
		cond.timer = timer_output;
		// RULE_15 agreement with reference
		cond.agree_b = in_band(speed, speed_ref, cfg.speed_width_b);
		// RULE_16 signed band, both
		cond.band_b = in_band(speed, cfg.speed_level_b, cfg.speed_width_b)
			&& in_band(speed_ref, cfg.speed_level_b, cfg.speed_width_b);
		cond.det_b_closed = !next_det_b_open;
		cond.det_b = next_det_b;
	end

	// Per-terminal selection, evaluated every cycle.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			next_terminal[i] = select_level(func_sel[i], cond, passthru[i]);
		end
	end

	// RULE_20 terminals low in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			terminal <= 3'h0;
			drive_ready <= 1'b0;
		end else begin
			terminal <= next_terminal;
			drive_ready <= cond.ready;
		end
	end

	// Travel commands pass only while ready; a blocked command is dropped, not held.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_accept <= 1'b0;
			down_accept <= 1'b0;
		end else begin
			// RULE_05 commands gated by ready
			up_accept <= up_cmd && cond.ready;
			down_accept <= down_cmd && cond.ready;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_det_a_set;
		(func_sel[0] == 9'h005 && {1'b0, speed_mag} > zext(cfg.speed_level_a)) |=> terminal[0];
	endproperty
	a_det_a_set: assert property (p_det_a_set) else $error("speed detection did not assert"); // RULE_01
	property p_det_a_reverse;
		(func_sel[0] == 9'h005 && speed[15] && speed_mag > {1'b0, cfg.speed_level_a}) |=> terminal[0];
	endproperty
	a_det_a_reverse: assert property (p_det_a_reverse) else $error("reverse speed not detected"); // RULE_02
	property p_fault_blocks_ready;
		fault_active |=> !drive_ready;
	endproperty
	a_fault_blocks_ready: assert property (p_fault_blocks_ready) else $error("ready during fault"); // RULE_03
	property p_safe_blocks_ready;
		(!cfg.config_bits[CFG_SAFE_READY_SEL] && (|safe_disable_open)) |=> !drive_ready;
	endproperty
	a_safe_blocks_ready: assert property (p_safe_blocks_ready) else $error("ready with safe open"); // RULE_04
	property p_cmd_gated;
		!drive_ready |-> !up_accept && !down_accept;
	endproperty
	a_cmd_gated: assert property (p_cmd_gated) else $error("command passed while not ready"); // RULE_05
	property p_bus_fault;
		(func_sel[0] == 9'h007 && dc_bus_fault) |=> terminal[0];
	endproperty
	a_bus_fault: assert property (p_bus_fault) else $error("bus fault not shown"); // RULE_06
	property p_control_fault;
		(func_sel[0] == 9'h00E && fault_code == CONTROL_FAULT_A) |=> !terminal[0];
	endproperty
	a_control_fault: assert property (p_control_fault) else $error("control fault shown"); // RULE_10
	property p_torque_wait;
		(func_sel[0] == 9'h00B && torque_cnt[0] <= cfg.torque_time_1) |=> !terminal[0];
	endproperty
	a_torque_wait: assert property (p_torque_wait) else $error("torque detected too early"); // RULE_08
	property p_invert;
		(func_sel[2] == 9'h10E && !fault_active) |=> terminal[2];
	endproperty
	a_invert: assert property (p_invert) else $error("inverse output wrong"); // RULE_19
	property p_passthru;
		(func_sel[2] == 9'h00F) ##1 (func_sel[2] == 9'h00F) |-> terminal[2] == $past(passthru[2]);
	endproperty
	a_passthru: assert property (p_passthru) else $error("pass-through mismatch"); // RULE_11

endmodule // status_output_select

`default_nettype wire

//--- tb/drive_status_output_select_tb_top.sv
// Self-checking bench for the status output block and its controller model.
// Assumes the package constants and a zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none

module drive_status_output_select_tb_top
	import status_output_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, fault_code;
	logic [31:0] pwdata, prdata;
	logic signed [15:0] speed, speed_ref;
	logic [15:0] torque, dc_bus_voltage, control_supply_voltage;
	logic dc_bus_fault, fault_active, supply_failure, param_error, overvoltage, motor_stopped;
	logic param_editing, output_inhibited, minor_fault, timer_output, up_cmd, down_cmd, go_up, go_down;
	logic [1:0] safe_disable_open;
	logic [2:0] reset_attempt, terminal, seen_terminal;
	logic drive_ready, up_accept, down_accept;
	int n_errors, samples_checked;

	// A short torque tick keeps the timed detections within a few dozen cycles.
	status_output_select #(.TICK_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .speed(speed), .speed_ref(speed_ref), .torque(torque),
		.dc_bus_voltage(dc_bus_voltage), .control_supply_voltage(control_supply_voltage),
		.dc_bus_fault(dc_bus_fault), .fault_active(fault_active), .fault_code(fault_code),
		.supply_failure(supply_failure), .param_error(param_error), .overvoltage(overvoltage),
		.motor_stopped(motor_stopped), .param_editing(param_editing), .safe_disable_open(safe_disable_open),
		.output_inhibited(output_inhibited), .minor_fault(minor_fault), .reset_attempt(reset_attempt),
		.timer_output(timer_output), .up_cmd(up_cmd), .down_cmd(down_cmd), .terminal(terminal),
		.drive_ready(drive_ready), .up_accept(up_accept), .down_accept(down_accept));

	elevator_ctrl_model ctrl (.pclk(pclk), .presetn(presetn), .go_up(go_up), .go_down(go_down),
		.terminal(terminal), .up_cmd(up_cmd), .down_cmd(down_cmd), .seen_terminal(seen_terminal));

	always #50 pclk = ~pclk;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge pclk);
			n++;
		end
		q = prdata;
		e = pslverr;
		chk("pready", 32'h1, {31'h0, pready});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		chk("write error", 32'h0, {31'h0, e});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic expe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk("read data", exp, q);
		chk("read error", {31'h0, expe}, {31'h0, e});
	endtask

	// Three edges cover the input sample and any registered accept stage.
	task automatic settle();
		repeat (3) @(posedge pclk);
		#1;
	endtask

	task automatic t0(input logic exp);
		settle();
		chk("terminal0", {31'h0, exp}, {31'h0, terminal[0]});
	endtask

	task automatic step(input logic signed [15:0] s, input logic signed [15:0] r, input logic exp);
		@(posedge pclk);
		speed <= s;
		speed_ref <= r;
		t0(exp);
	endtask

	// Timed detections are waited for under a bound, never a fixed count.
	task automatic wait_t0(input logic exp);
		int n;
		n = 0;
		while (terminal[0] !== exp && n < 60) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk("timed terminal0", {31'h0, exp}, {31'h0, terminal[0]});
	endtask

	task automatic t_regs();
		rd(OFS_FUNC_SEL0, 32'h0000000E, 1'b0);
		rd(OFS_FUNC_SEL1, 32'h00000006, 1'b0);
		rd(OFS_FUNC_SEL2, 32'h00000050, 1'b0);
		rd(OFS_CONFIG, 32'h00000000, 1'b0);
		rd(8'h3C, 32'h00000000, 1'b1);
	endtask

	task automatic t_speed();
		wr(OFS_SPEED_LEVEL_A, 32'h64);
		wr(OFS_SPEED_WIDTH_A, 32'h14);
		wr(OFS_SPEED_LEVEL_B, 32'hC8);
		wr(OFS_SPEED_WIDTH_B, 32'h1E);
		wr(OFS_FUNC_SEL0, FN_SPEED_DET_A);
		step(101, 0, 1);
		step(85, 0, 1);
		step(79, 0, 0);
		step(100, 0, 0);
		step(-101, 0, 1);
		step(-80, 0, 1);
		step(-79, 0, 0);
		wr(OFS_FUNC_SEL0, FN_AGREE_B);
		step(530, 500, 1);
		step(531, 500, 0);
		step(-530, -500, 1);
		wr(OFS_FUNC_SEL0, FN_BAND_B);
		step(210, 190, 1);
		step(231, 200, 0);
		step(-210, -190, 0);
		wr(OFS_FUNC_SEL0, FN_DET_B_OPEN);
		step(230, 0, 1);
		step(231, 0, 0);
		step(200, 0, 0);
		step(199, 0, 1);
		wr(OFS_FUNC_SEL0, FN_DET_B);
		step(201, 0, 1);
		step(170, 0, 1);
		step(169, 0, 0);
		step(-201, 0, 0);
		step(0, 0, 0);
	endtask

	task automatic t_fault();
		wr(OFS_FUNC_SEL0, FN_FAULT);
		@(posedge pclk);
		fault_active <= 1'b1;
		t0(1);
		@(posedge pclk);
		fault_code <= CONTROL_FAULT_A;
		t0(0);
		@(posedge pclk);
		fault_code <= CONTROL_FAULT_B;
		t0(0);
		wr(OFS_FUNC_SEL0, 32'h10E);
		wr(OFS_FUNC_SEL2, 32'h10E);
		t0(1);
		@(posedge pclk);
		fault_code <= 8'h05;
		t0(0);
		chk("terminal2", 32'h0, {31'h0, terminal[2]});
		@(posedge pclk);
		fault_active <= 1'b0;
		t0(1);
		chk("terminal2", 32'h1, {31'h0, terminal[2]});
	endtask

	// Each plain code is driven low then high through its own source.
	task automatic t_simple();
		logic [7:0] fn [6] = '{FN_UNDERVOLT, FN_INHIBIT, FN_MINOR, FN_RESET_TRY, FN_TIMER, FN_PASSTHRU};
		wr(OFS_UNDERVOLT, 32'h32);
		for (int i = 0; i < 6; i++) begin
			wr(OFS_FUNC_SEL0, {24'h0, fn[i]});
			for (int v = 0; v < 2; v++) begin
				if (i == 5) wr(OFS_PASSTHRU, v);
				@(posedge pclk);
				dc_bus_voltage <= (i == 0 && v == 1) ? 16'h0028 : 16'h03E8;
				output_inhibited <= (i == 1 && v == 1);
				minor_fault <= (i == 2 && v == 1);
				reset_attempt <= (i == 3 && v == 1) ? 3'b100 : 3'b000;
				timer_output <= (i == 4 && v == 1);
				t0(v[0]);
			end
		end
		wr(OFS_FUNC_SEL2, FN_PASSTHRU);
		wr(OFS_PASSTHRU, 32'h5);
		settle();
		chk("model view", 32'h5, {29'h0, seen_terminal & 3'b101});
		wr(OFS_FUNC_SEL0, FN_UNDERVOLT);
		@(posedge pclk);
		control_supply_voltage <= 16'h0028;
		t0(1);
		@(posedge pclk);
		control_supply_voltage <= 16'h03E8;
		dc_bus_fault <= 1'b1;
		t0(1);
		@(posedge pclk);
		dc_bus_fault <= 1'b0;
		t0(0);
	endtask

	task automatic t_torque();
		wr(OFS_TORQUE_LEVEL_1, 32'h12C);
		wr(OFS_TORQUE_TIME_1, 32'h2);
		wr(OFS_FUNC_SEL0, FN_TORQUE_1);
		@(posedge pclk);
		torque <= 16'h0190;
		repeat (6) @(posedge pclk);
		#1;
		chk("torque early", 32'h0, {31'h0, terminal[0]});
		wait_t0(1);
		@(posedge pclk);
		torque <= 16'h0064;
		wait_t0(0);
		wr(OFS_TORQUE_LEVEL_2, 32'h12C);
		wr(OFS_TORQUE_TIME_2, 32'h1);
		@(posedge pclk);
		torque <= 16'h0190;
		wr(OFS_CONFIG, 32'h2);
		wr(OFS_FUNC_SEL0, FN_TORQUE_2);
		t0(0);
		@(posedge pclk);
		torque <= 16'h0064;
		repeat (3) @(posedge pclk);
		#1;
		chk("torque2 early", 32'h0, {31'h0, terminal[0]});
		wait_t0(1);
		wr(OFS_CONFIG, 32'h0);
	endtask

	// Pass 0 sets no blocker, passes 5, 8 and 9 an input that does not block, each other pass one; bit i of exp is the expected ready level.
	task automatic t_ready();
		logic [9:0] exp = 10'b1100100001;
		go_up <= 1'b1;
		go_down <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			if (i == 8) wr(OFS_CONFIG, 32'hC);
			@(posedge pclk);
			fault_active <= (i == 1);
			supply_failure <= (i == 2);
			param_error <= (i == 3);
			overvoltage <= (i == 4 || i == 5);
			motor_stopped <= (i == 4);
			param_editing <= (i == 6 || i == 8);
			safe_disable_open <= (i == 7 || i == 9) ? 2'b10 : 2'b00;
			settle();
			chk("ready", {28'h0, {4{exp[i]}}}, {28'h0, drive_ready, terminal[1], up_accept, down_accept});
		end
		wr(OFS_CONFIG, 32'h0);
	endtask

	// A reset in mid-run drops every terminal at once.
	task automatic t_reset_mid();
		@(posedge pclk);
		fault_active <= 1'b1;
		presetn <= 1'b0;
		@(posedge pclk);
		#1;
		chk("terminal in reset", 32'h0, {29'h0, terminal});
		@(posedge pclk);
		presetn <= 1'b1;
		t0(1);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{speed, speed_ref, torque} = '0;
		dc_bus_voltage = 16'h03E8;
		control_supply_voltage = 16'h03E8;
		{dc_bus_fault, fault_active, supply_failure, param_error, overvoltage, motor_stopped} = '0;
		{param_editing, output_inhibited, minor_fault, timer_output, go_up, go_down} = '0;
		fault_code = 8'h05;
		safe_disable_open = 2'b00;
		reset_attempt = 3'b000;
		n_errors = 0;
		samples_checked = 0;
		repeat (15) @(posedge pclk);
		#1;
		chk("terminal at reset", 32'h0, {29'h0, terminal});
		@(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_speed();
		t_fault();
		t_simple();
		t_torque();
		t_ready();
		t_reset_mid();
		report_and_stop();
	end

	// The whole sequence needs a few hundred cycles; this span is far beyond it.
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		report_and_stop();
	end
endmodule // drive_status_output_select_tb_top

`default_nettype wire

//--- tb/elevator_ctrl_model.sv
// Model of the elevator controller that reads the status terminals.
// Assumes the bench asks for travel through go_up and go_down.
`timescale 1ns/1ps
`default_nettype none

module elevator_ctrl_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go_up,
	input wire logic go_down,
	input wire logic [2:0] terminal,
	output logic up_cmd,
	output logic down_cmd,
	output logic [2:0] seen_terminal
);
	// Travel commands leave on an edge, so the drive never sees a glitch.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_cmd <= 1'b0;
			down_cmd <= 1'b0;
		end else begin
			up_cmd <= go_up;
			down_cmd <= go_down;
		end
	end

	// terminal state read
	// The controller scans all terminals each cycle, pass-through ones too.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_terminal <= 3'h0;
		end else begin
			seen_terminal <= terminal;
		end
	end
endmodule // elevator_ctrl_model

`default_nettype wire
